// file: rtl/rbms_top.sv
/*
 Reset and boot-mode select: reset fan-out, reset indication stretch, latched
 clock boot mode and serial flash programming mode entry.
 Assumes SYS_CLK is the CPU clock at 200 MHz and mode pins are asynchronous.
*/
// Operation
// RQ1: External reset resets core asynchronously, immediately
// RQ2: Reset indication low 512 clocks after release
// RQ3: Code 01 crystal no PLL; 11 crystal PLL
// RQ4: Codes 00/10 use crystal pin source
// RQ5: Crystal pin is input when upper bit set
// RQ6: Boot config with test low enters flash programming
// RQ7: Clock output follows system clock
// RQ8: Reference input unused only for on-chip oscillator
// RQ9: Latch modes at reset release until next
`timescale 1ns/1ps
`include "rbms_cfg.svh"

module rbms_top (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [1:0] CLOCK_BOOT_SELECT,
    input wire logic CRYSTAL_OUT_PIN_I,
    output logic CRYSTAL_OUT_PIN_O,
    output logic CRYSTAL_OUT_PIN_OE,
    input wire logic BOOT_CONFIG_PIN,
    input wire logic TEST_PIN,
    output logic CORE_RESET_B,
    output logic RESET_INDICATION_OUT,
    output logic SYSTEM_CLOCK_OUT,
    output logic PLL_ENABLE,
    output logic [1:0] CLOCK_SOURCE,
    output logic CLOCK_REFERENCE_IN_USED,
    output logic SERIAL_FLASH_PORT_EN,
    output logic MODE_VALID
);
    logic [1:0] cbs_s1_r, cbs_s2_r;
    logic xt_s1_r, xt_s2_r, bc_s1_r, bc_s2_r, ts_s1_r, ts_s2_r;
    rbms_pkg::rbms_state_e state_r, state_nxt;
    logic [`RBMS_CNT_W-1:0] cnt_r, cnt_nxt;
    rbms_pkg::rbms_mode_s mode_r, mode_nxt;
    logic reset_indication_out_r, reset_indication_out_nxt;
    logic [1:0] hold_hist_r;
    logic latch_now, oe_r, oe_nxt;

    assign latch_now = (state_r == rbms_pkg::RBMS_ST_RESET)
        && (cnt_r == `RBMS_CNT_W'(`RBMS_LATCH_CNT));

    // Two-flop synchronisers for mode pins
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cbs_s1_r <= 2'h0;
            cbs_s2_r <= 2'h0;
            {xt_s1_r, xt_s2_r, bc_s1_r, bc_s2_r, ts_s1_r, ts_s2_r} <= 6'h00;
        end else begin
            cbs_s1_r <= CLOCK_BOOT_SELECT;
            cbs_s2_r <= cbs_s1_r;
            xt_s1_r <= CRYSTAL_OUT_PIN_I;
            xt_s2_r <= xt_s1_r;
            bc_s1_r <= BOOT_CONFIG_PIN;
            bc_s2_r <= bc_s1_r;
            ts_s1_r <= TEST_PIN;
            ts_s2_r <= ts_s1_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        mode_nxt = mode_r;
        reset_indication_out_nxt = reset_indication_out_r;
        unique case (state_r)
            rbms_pkg::RBMS_ST_RESET: begin
                // Sample after synchronisers have filled
                if (latch_now) begin
                    mode_nxt.pll_en = cbs_s2_r[`RBMS_CBS_PIN_BIT]; // RQ3 RQ4
                    if (cbs_s2_r == `RBMS_CBS_CRYSTAL_OUT_PIN_NOPLL || cbs_s2_r == `RBMS_CBS_CRYSTAL_OUT_PIN_PLL) begin
                        mode_nxt.src = rbms_pkg::RBMS_SRC_CRYSTAL; // RQ3
                    end else if (xt_s2_r) begin
                        mode_nxt.src = rbms_pkg::RBMS_SRC_ONCHIP; // RQ4
                    end else begin
                        mode_nxt.src = rbms_pkg::RBMS_SRC_EXT_OSC; // RQ4
                    end
                    mode_nxt.ref_in_used = !(!cbs_s2_r[0] && xt_s2_r); // RQ8
                    mode_nxt.flash_prog = bc_s2_r && !ts_s2_r; // RQ6
                    state_nxt = rbms_pkg::RBMS_ST_HOLD; // RQ9
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + `RBMS_CNT_W'(1);
                end
            end
            rbms_pkg::RBMS_ST_HOLD: begin
                if (cnt_r == `RBMS_CNT_W'(`RBMS_HOLD_END)) begin
                    reset_indication_out_nxt = 1'b1; // RQ2
                    state_nxt = rbms_pkg::RBMS_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + `RBMS_CNT_W'(1);
                end
            end
            rbms_pkg::RBMS_ST_RUN: begin
                state_nxt = rbms_pkg::RBMS_ST_RUN; // RQ9
            end
            default: begin
                state_nxt = rbms_pkg::RBMS_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin // RQ1
            state_r <= rbms_pkg::RBMS_ST_RESET;
            cnt_r <= '0;
            mode_r <= '0;
            reset_indication_out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
            reset_indication_out_r <= reset_indication_out_nxt;
        end
    end

    assign CORE_RESET_B = RST_B; // RQ1
    assign RESET_INDICATION_OUT = reset_indication_out_r;
    assign SYSTEM_CLOCK_OUT = SYS_CLK; // RQ7
    assign PLL_ENABLE = mode_r.pll_en;
    assign CLOCK_SOURCE = mode_r.src;
    assign CLOCK_REFERENCE_IN_USED = mode_r.ref_in_used;
    assign SERIAL_FLASH_PORT_EN = mode_r.flash_prog; // RQ6
    assign MODE_VALID = (state_r != rbms_pkg::RBMS_ST_RESET);
    // Crystal pin stays released until the modes are latched
    assign CRYSTAL_OUT_PIN_OE = oe_r; // RQ5
    assign CRYSTAL_OUT_PIN_O = 1'b0;

    // Drive decision taken from the latched select, not the live pins
    always_comb begin
        oe_nxt = oe_r;
        if (latch_now) begin
            oe_nxt = !cbs_s2_r[`RBMS_CBS_PIN_BIT]; // RQ5
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= oe_nxt;
        end
    end

    // Helper: history of indication for assertions
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hold_hist_r <= 2'h0;
        end else begin
            hold_hist_r <= {hold_hist_r[0], reset_indication_out_r};
        end
    end

    rst_out_low_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ2
        (state_r != rbms_pkg::RBMS_ST_RUN) |-> !RESET_INDICATION_OUT)
        else $error("Reset indication released early");
    rst_out_time_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ2
        $rose(RESET_INDICATION_OUT) |-> $past(cnt_r) == `RBMS_CNT_W'(`RBMS_HOLD_END))
        else $error("Reset indication released at wrong count");
    rst_out_stay_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        hold_hist_r[1] |-> RESET_INDICATION_OUT)
        else $error("Reset indication fell without reset");
    mode_stable_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        (state_r == rbms_pkg::RBMS_ST_RUN) |=> $stable(mode_r))
        else $error("Mode changed outside reset");
    crystal_out_pin_src_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ3
        latch_now |=> ((CLOCK_SOURCE == rbms_pkg::RBMS_SRC_CRYSTAL) == $past(cbs_s2_r[0])))
        else $error("Crystal source mis-selected");
    ref_use_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ8
        MODE_VALID |-> (CLOCK_REFERENCE_IN_USED == (CLOCK_SOURCE != rbms_pkg::RBMS_SRC_ONCHIP)))
        else $error("Reference input use wrong");
    pin_oe_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ5
        latch_now |=> (CRYSTAL_OUT_PIN_OE == !$past(cbs_s2_r[1])))
        else $error("Crystal pin drive wrong for select");
    core_rst_a: assert property (@(posedge SYS_CLK) // RQ1
        CORE_RESET_B == RST_B)
        else $error("Core reset not following input");
    oe_pre_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ5
        !MODE_VALID |-> !CRYSTAL_OUT_PIN_OE)
        else $error("Crystal pin driven before latch");
    oe_kept_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        MODE_VALID |=> $stable(CRYSTAL_OUT_PIN_OE))
        else $error("Crystal pin drive changed outside reset");
    pll_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ3
        latch_now |=> (PLL_ENABLE == $past(cbs_s2_r[1])))
        else $error("PLL enable wrong for select");
    src_pin_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ4
        (latch_now && !cbs_s2_r[0]) |=> (CLOCK_SOURCE == ($past(xt_s2_r) ?
            rbms_pkg::RBMS_SRC_ONCHIP : rbms_pkg::RBMS_SRC_EXT_OSC)))
        else $error("Pin-selected source wrong");
    ref_pin_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ8
        (latch_now && !cbs_s2_r[0]) |=> (CLOCK_REFERENCE_IN_USED == !$past(xt_s2_r)))
        else $error("Reference use wrong for crystal level");
    flash_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ6
        latch_now |=> (SERIAL_FLASH_PORT_EN == $past(bc_s2_r && !ts_s2_r)))
        else $error("Flash programming mode entry wrong");
    flash_valid_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ6
        SERIAL_FLASH_PORT_EN |-> MODE_VALID)
        else $error("Flash programming before latch");
    valid_stay_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        MODE_VALID |=> MODE_VALID)
        else $error("Mode valid dropped outside reset");
    latch_valid_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        latch_now |=> MODE_VALID)
        else $error("Mode valid missing after latch");
    pre_latch_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        !MODE_VALID |-> (CLOCK_SOURCE == 2'h0 && !PLL_ENABLE))
        else $error("Modes shown before latch");
    src_legal_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ3
        CLOCK_SOURCE != 2'h3)
        else $error("Clock source code illegal");
    fill_wait_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ9
        (state_r == rbms_pkg::RBMS_ST_RESET) |-> (cnt_r <= `RBMS_CNT_W'(`RBMS_LATCH_CNT)))
        else $error("Fill count overran");
    cnt_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ2
        (state_r == rbms_pkg::RBMS_ST_HOLD) |-> (cnt_r <= `RBMS_CNT_W'(`RBMS_HOLD_END)))
        else $error("Hold count overran");
    reset_indication_out_run_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ2
        (state_r == rbms_pkg::RBMS_ST_RUN) |-> RESET_INDICATION_OUT)
        else $error("Reset indication low while running");
endmodule // rbms_top

// file: rtl/rbms_cfg.svh
/*
 Timing counts and pin-code constants for the reset and boot-mode select block.
 Assumes inclusion by the design module only.
*/
`ifndef RBMS_CFG_SVH
`define RBMS_CFG_SVH

`define RBMS_RST_HOLD_CLKS 512
`define RBMS_CNT_W 10
`define RBMS_LATCH_CNT 2
`define RBMS_HOLD_END (`RBMS_RST_HOLD_CLKS - `RBMS_LATCH_CNT - 2)
`define RBMS_CBS_CRYSTAL_OUT_PIN_NOPLL 2'b01
`define RBMS_CBS_CRYSTAL_OUT_PIN_PLL 2'b11
`define RBMS_CBS_PIN_NOPLL 2'b00
`define RBMS_CBS_PIN_PLL 2'b10
`define RBMS_CBS_PIN_BIT 1

`endif

// file: rtl/rbms_pkg.sv
/*
 Types for the reset and boot-mode select block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rbms_pkg;
    typedef enum logic [1:0] {
        RBMS_SRC_CRYSTAL = 2'h0,
        RBMS_SRC_EXT_OSC = 2'h1,
        RBMS_SRC_ONCHIP = 2'h2
    } rbms_src_e;

    typedef enum logic [1:0] {
        RBMS_ST_RESET = 2'h0,
        RBMS_ST_HOLD = 2'h1,
        RBMS_ST_RUN = 2'h2
    } rbms_state_e;

    typedef struct packed {
        logic pll_en;
        rbms_src_e src;
        logic ref_in_used;
        logic flash_prog;
    } rbms_mode_s;
endpackage

// file: tb/rbms_board.sv
/*
 Board model: strap levels on the mode pins and the crystal pin wire.
 Assumes the bench changes straps only off the sampling edge.
*/
`timescale 1ns/1ps
module rbms_board (
    input wire logic [4:0] strap,
    input wire logic xo,
    input wire logic xoe,
    output logic [1:0] cbs,
    output logic xi,
    output logic boot,
    output logic test
);
    assign cbs = strap[4:3];
    // Chip drive wins on the crystal wire while enabled
    assign xi = xoe ? xo : strap[2];
    assign boot = strap[1];
    assign test = strap[0];
endmodule // rbms_board

// file: tb/test_reset_and_boot_mode_select.sv
/*
 Self-checking bench for the reset and boot-mode select block.
 Assumes rbms_pkg is compiled first and the board model is present.
*/
`timescale 1ns/1ps
module test_reset_and_boot_mode_select;
    logic SYS_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [4:0] strap = 5'h00;
    logic [1:0] cbs, src;
    logic xi, xo, xoe, boot, test, core_b, ind, sclk, pll, ref_u, fl, vld;
    logic [9:0] exp_m;
    integer seed = 32'hf68ee145;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    initial begin
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    rbms_board u_rbms_board (.strap(strap), .xo(xo), .xoe(xoe), .cbs(cbs), .xi(xi),
        .boot(boot), .test(test));
    rbms_top u_rbms_top (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CLOCK_BOOT_SELECT(cbs),
        .CRYSTAL_OUT_PIN_I(xi), .CRYSTAL_OUT_PIN_O(xo), .CRYSTAL_OUT_PIN_OE(xoe),
        .BOOT_CONFIG_PIN(boot), .TEST_PIN(test), .CORE_RESET_B(core_b),
        .RESET_INDICATION_OUT(ind), .SYSTEM_CLOCK_OUT(sclk), .PLL_ENABLE(pll),
        .CLOCK_SOURCE(src), .CLOCK_REFERENCE_IN_USED(ref_u),
        .SERIAL_FLASH_PORT_EN(fl), .MODE_VALID(vld));
    // Strap bits: code[4:3], crystal level, boot config, test
    function automatic logic [9:0] exp_mode(input logic [4:0] s);
        logic lvl;
        lvl = s[2];
        exp_mode = {5'h00, s[4], 2'h0, ~(~s[3] & lvl), s[1] & ~s[0]};
        if (!s[3]) exp_mode[3:2] = lvl ? rbms_pkg::RBMS_SRC_ONCHIP : rbms_pkg::RBMS_SRC_EXT_OSC;
    endfunction
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge SYS_CLK);
        for (int t = 0; t < 14; t++) begin
            @(posedge SYS_CLK);
            strap <= (t < 8) ? {t[2:0], t[0], t[1]} : 5'($random(seed));
            RST_B <= 1'b0;
            #1;
            chk("core_reset", 10'h0, {9'h0, core_b});
            chk("reset_ind", 10'h0, {9'h0, ind});
            @(posedge SYS_CLK);
            RST_B <= 1'b1;
            exp_m = exp_mode(strap);
            n = 0;
            while (n < 600 && ind !== 1'b1) begin
                @(posedge SYS_CLK);
                n++;
                if (n == 4) strap <= 5'($random(seed));
                #1;
                if (n == 3) begin
                    chk("mode", exp_m, {5'h0, pll, src, ref_u, fl});
                    chk("crystal_out_pin_oe", {9'h0, ~exp_m[4]}, {9'h0, xoe});
                    chk("valid", 10'h1, {9'h0, vld});
                    chk("core_run", 10'h1, {9'h0, core_b});
                    chk("crystal_out_pin_o", 10'h0, {9'h0, xo});
                end
            end
            chk("hold_clks", 10'd512, 10'(n));
            if (ind !== 1'b1) give_verdict();
            chk("mode_kept", exp_m, {5'h0, pll, src, ref_u, fl});
            chk("clk_hi", {9'h0, SYS_CLK}, {9'h0, sclk});
            #2;
            chk("clk_lo", {9'h0, SYS_CLK}, {9'h0, sclk});
        end
        give_verdict();
    end
endmodule // test_reset_and_boot_mode_select
